/* bench/time_base_up_tb.sv */
// Self-checking bench for the upcounting time-base unit
`timescale 1ns/1ps
`default_nettype none
module time_base_up_tb;
   logic        clk;
   logic        rstn;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat;
   logic [31:0] rdat;
   logic        ack;
   logic        irq;
   logic        updateEvent;
   logic [15:0] countValue;
   logic [31:0] r;
   int          n_fail;
   int          samples_checked;
   int          n;
   localparam logic [31:0] COUNTER_ENABLE  = 32'h1 << tb_timer_pkg::CEN_BIT;
   localparam logic [31:0] UPDATE_DISABLE = 32'h1 << tb_timer_pkg::UPDATE_DISABLE_BIT;
   localparam logic [31:0] UPDATE_SOURCE_SELECT  = 32'h1 << tb_timer_pkg::URS_BIT;
   localparam logic [31:0] PRELOAD_ENABLE = 32'h1 << tb_timer_pkg::PRELOAD_ENABLE_BIT;

   time_base_up u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq(irq), .updateEvent(updateEvent), .countValue(countValue));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic print_verdict;
      if (n_fail == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // Request held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1)
      begin
         n_fail++;
         print_verdict();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, r);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h00000000, r);
      chk(nm, r, e);
   endtask

   // Cycles until the next update pulse
   task automatic waitEv(output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
      end while (updateEvent !== 1'b1 && c < 2000);
      if (c >= 2000)
      begin
         n_fail++;
         print_verdict();
      end
   endtask

   initial
   begin
      n_fail = 0;
      samples_checked = 0;
      rstn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      dat = 32'h00000000;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rdc("reload rst", tb_timer_pkg::RELOAD_OFS, 32'(tb_timer_pkg::RELOAD_RST));
      rdc("count rst", tb_timer_pkg::COUNT_OFS, 32'(tb_timer_pkg::ZERO16));
      rdc("div rst", tb_timer_pkg::DIV_OFS, 32'h00000000);
      rdc("repeat rst", tb_timer_pkg::REPEAT_OFS, 32'(tb_timer_pkg::REPEAT_RST));
      rdc("unmapped", 8'h20, 32'h00000000);
      // Plain wrap period is reload plus one
      wr(tb_timer_pkg::RELOAD_OFS, 32'h00000013);
      wr(tb_timer_pkg::CTRL_OFS, COUNTER_ENABLE | PRELOAD_ENABLE);
      waitEv(n);
      waitEv(n);
      chk("period 20", 32'(n), 32'h00000014);
      // New reload and divider wait for the next update
      wr(tb_timer_pkg::RELOAD_OFS, 32'h00000001);
      wr(tb_timer_pkg::DIV_OFS, 32'h00000001);
      waitEv(n);
      chk("old period kept", 32'(n < 20), 32'h00000001);
      waitEv(n);
      chk("period 4", 32'(n), 32'h00000004);
      rdc("reload preload", tb_timer_pkg::RELOAD_OFS, 32'h00000001);
      wr(tb_timer_pkg::REPEAT_OFS, 32'h00000002);
      waitEv(n);
      waitEv(n);
      chk("repeat period", 32'(n), 32'h0000000C);
      // Stopped counter, flag, mask and clear
      wr(tb_timer_pkg::CTRL_OFS, PRELOAD_ENABLE);
      rdc("flag set", tb_timer_pkg::STATUS_OFS, 32'h00000001);
      wr(tb_timer_pkg::MASK_OFS, 32'h00000001);
      @(posedge clk);
      chk("irq on", 32'(irq), 32'h00000001);
      r = 32'(countValue);
      repeat (20) @(posedge clk);
      chk("count frozen", 32'(countValue), r);
      wr(tb_timer_pkg::STATUS_OFS, 32'h00000001);
      rdc("flag clear", tb_timer_pkg::STATUS_OFS, 32'h00000000);
      chk("irq off", 32'(irq), 32'h00000000);
      // Software update with and without source select
      wr(tb_timer_pkg::COUNT_OFS, 32'h00000005);
      rdc("count write", tb_timer_pkg::COUNT_OFS, 32'h00000005);
      wr(tb_timer_pkg::CTRL_OFS, PRELOAD_ENABLE | UPDATE_SOURCE_SELECT);
      wr(tb_timer_pkg::EVGEN_OFS, 32'h00000001);
      rdc("count restart", tb_timer_pkg::COUNT_OFS, 32'h00000000);
      rdc("no flag", tb_timer_pkg::STATUS_OFS, 32'h00000000);
      wr(tb_timer_pkg::CTRL_OFS, PRELOAD_ENABLE);
      wr(tb_timer_pkg::EVGEN_OFS, 32'h00000001);
      rdc("sw flag", tb_timer_pkg::STATUS_OFS, 32'h00000001);
      wr(tb_timer_pkg::STATUS_OFS, 32'h00000001);
      // Update disable blocks overflow updates
      wr(tb_timer_pkg::CTRL_OFS, COUNTER_ENABLE | UPDATE_DISABLE | PRELOAD_ENABLE);
      wr(tb_timer_pkg::RELOAD_OFS, 32'h00000002);
      n = 0;
      repeat (60)
      begin
         @(posedge clk);
         n += int'(updateEvent === 1'b1);
      end
      chk("no update", 32'(n), 32'h00000000);
      wr(tb_timer_pkg::CTRL_OFS, COUNTER_ENABLE | PRELOAD_ENABLE);
      waitEv(n);
      waitEv(n);
      chk("period after enable", 32'(n), 32'h00000012);
      print_verdict();
   end
endmodule
`default_nettype wire

/* design/tb_timer_pkg.sv */
// Package for the upcounting time-base unit: register map, fields, resets
package tb_timer_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] EVGEN_OFS  = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;
   localparam logic [7:0] MASK_OFS   = 8'h0C;
   localparam logic [7:0] COUNT_OFS  = 8'h10;
   localparam logic [7:0] DIV_OFS    = 8'h14;
   localparam logic [7:0] RELOAD_OFS = 8'h18;
   localparam logic [7:0] REPEAT_OFS = 8'h1C;
   // control_one bit positions
   localparam int CEN_BIT  = 0;
   localparam int UPDATE_DISABLE_BIT = 1;
   localparam int URS_BIT  = 2;
   localparam int PRELOAD_ENABLE_BIT = 7;
   // event_generation_reg and status_flags bit
   localparam int UG_BIT  = 0;
   localparam int UIF_BIT = 0;
   // Reset values
   localparam logic [15:0] RELOAD_RST = 16'hFFFF;
   localparam logic [15:0] ZERO16     = 16'h0000;
   localparam logic [7:0]  REPEAT_RST = 8'h00;

   typedef struct packed {
      logic counter_enable;
      logic update_disable;
      logic update_source_select;
      logic preload_enable;
   } ctrl_t;
endpackage

/* design/time_base_up.sv */
// Upcounting time-base unit with Wishbone register slave
//
// Functional notes
// [RULE1] 16-bit counter, reloaded from reload value, advanced by prescaler output.
// [RULE2] Count, reload and divider are readable and writable at any time; a count write in the same cycle as an overflow is lost.
// [RULE3] Reload accesses hit the preload copy, not the shadow.
// [RULE4] Preload disabled: shadow follows at once; enabled: copied at update only.
// [RULE5] Overflow issues update only while update disable is 0; software too.
// [RULE6] Counter tick gated by counter enable.
// [RULE7] Counting begins one clock after counter enable is set.
// [RULE8] Prescaler is 16-bit counter, ratio 1 through 65536.
// [RULE9] Divider setting is buffered, effective at next update.
// [RULE10] Count 0 up to reload, wrap to 0, signal overflow.
// [RULE11] With repetition, update after repeat-count plus one overflows; otherwise every overflow.
// [RULE12] Writing update generate causes an update event.
// [RULE13] Update disable blocks all updates and shadow transfers; repetition counter still reloads, shadow follows if preload off.
// [RULE14] Generated update restarts counter and prescaler counter from 0.
// [RULE15] Source select set: software update sets no flag nor interrupt.
// [RULE16] Update sets update flag, subject to source select.
// [RULE17] Update reloads repetition counter, reload shadow and prescaler buffer.
// [RULE18] Division ratio equals divider setting plus one.
// [RULE19] Request held while flag set and enabled, until cleared.
`timescale 1ns/1ps
`default_nettype none
module time_base_up
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Events
   output logic             irq,
   output logic             updateEvent,
   output logic [15:0]      countValue
);
   tb_timer_pkg::ctrl_t ctrl;
   logic [15:0] count;
   logic [15:0] dividerSetting;
   logic [15:0] divBuffer;
   logic [15:0] preCount;
   logic [15:0] reloadPreload;
   logic [15:0] reloadShadow;
   logic [7:0]  repeatSetting;
   logic [7:0]  repeatCount;
   logic        updateFlag;
   logic        updateMask;
   logic        cenLate;

   // Bus decode
   wire access  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wrStb   = access & wb_we_i;
   wire lane0   = wb_sel_i[0];
   wire selCtrl   = wb_adr_i == tb_timer_pkg::CTRL_OFS;
   wire selEvgen  = wb_adr_i == tb_timer_pkg::EVGEN_OFS;
   wire selStatus = wb_adr_i == tb_timer_pkg::STATUS_OFS;
   wire selMask   = wb_adr_i == tb_timer_pkg::MASK_OFS;
   wire selCount  = wb_adr_i == tb_timer_pkg::COUNT_OFS;
   wire selDiv    = wb_adr_i == tb_timer_pkg::DIV_OFS;
   wire selReload = wb_adr_i == tb_timer_pkg::RELOAD_OFS;
   wire selRepeat = wb_adr_i == tb_timer_pkg::REPEAT_OFS;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // Software update request
   // [RULE12] UG write
   wire swUpdate = wrStb & selEvgen & lane0 & wb_dat_i[tb_timer_pkg::UG_BIT];
   // [RULE8] prescaler tick
   // [RULE18] ratio divider plus one
   wire preWrap  = preCount == divBuffer;
   // [RULE6] tick gating
   // [RULE7] one clock late start
   wire counterTick = cenLate & preWrap;
   // [RULE10] overflow at reload value
   wire overflow = counterTick & (count == reloadShadow);
   // [RULE11] repetition pacing
   wire repDone  = repeatCount == tb_timer_pkg::REPEAT_RST;
   // [RULE5] overflow update gated
   // [RULE13] update disable blocks
   wire nextUpdate = ~ctrl.update_disable & ((overflow & repDone) | swUpdate);
   // [RULE15] quiet software update
   // [RULE16] flag source selection
   wire flagSet = nextUpdate & ~(swUpdate & ctrl.update_source_select);
   wire countWr = wrStb & selCount;

   assign updateEvent = nextUpdate;
   assign countValue  = count;
   // [RULE19] held request
   assign irq = updateFlag & updateMask;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl          <= '0;
         cenLate       <= 1'b0;
         updateMask    <= 1'b0;
         dividerSetting <= tb_timer_pkg::ZERO16;
         reloadPreload <= tb_timer_pkg::RELOAD_RST;
         repeatSetting <= tb_timer_pkg::REPEAT_RST;
      end
      else
      begin
         cenLate <= ctrl.counter_enable;
         if (wrStb & selCtrl & lane0)
         begin
            ctrl.counter_enable  <= wb_dat_i[tb_timer_pkg::CEN_BIT];
            ctrl.update_disable <= wb_dat_i[tb_timer_pkg::UPDATE_DISABLE_BIT];
            ctrl.update_source_select  <= wb_dat_i[tb_timer_pkg::URS_BIT];
            ctrl.preload_enable <= wb_dat_i[tb_timer_pkg::PRELOAD_ENABLE_BIT];
         end
         if (wrStb & selMask & lane0)
            updateMask <= wb_dat_i[tb_timer_pkg::UIF_BIT];
         // [RULE2] divider write any time
         if (wrStb & selDiv)
            dividerSetting <= merge16(dividerSetting, wb_dat_i, wb_sel_i);
         // [RULE3] preload copy written
         if (wrStb & selReload)
            reloadPreload <= merge16(reloadPreload, wb_dat_i, wb_sel_i);
         if (wrStb & selRepeat & lane0)
            repeatSetting <= wb_dat_i[7:0];
      end
   end

   // Shadow copies, counters
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         reloadShadow <= tb_timer_pkg::RELOAD_RST;
         divBuffer    <= tb_timer_pkg::ZERO16;
         repeatCount  <= tb_timer_pkg::REPEAT_RST;
         preCount     <= tb_timer_pkg::ZERO16;
         count        <= tb_timer_pkg::ZERO16;
      end
      else
      begin
         // [RULE4] shadow transfer mode
         // [RULE17] update side effects
         if (!ctrl.preload_enable || nextUpdate)
            reloadShadow <= reloadPreload;
         // [RULE9] buffered divider
         if (nextUpdate)
            divBuffer <= dividerSetting;
         // Pacing keeps its rate under update disable, so no wrap below zero
         if (nextUpdate || (overflow && repDone))
            repeatCount <= repeatSetting;
         else if (overflow)
            repeatCount <= repeatCount - 8'h01;
         // [RULE14] generated update restarts both
         if (swUpdate || preWrap || !cenLate)
            preCount <= tb_timer_pkg::ZERO16;
         else
            preCount <= preCount + 16'h0001;
         // [RULE1] counter advance
         if (swUpdate || overflow)
            count <= tb_timer_pkg::ZERO16;
         else if (countWr)
            count <= merge16(count, wb_dat_i, wb_sel_i);
         else if (counterTick)
            count <= count + 16'h0001;
      end
   end

   // Sticky flag: set wins over write-one clear
   always_ff @(posedge clk)
   begin
      if (!rstn)
         updateFlag <= 1'b0;
      else if (flagSet)
         updateFlag <= 1'b1;
      else if (wrStb & selStatus & lane0 & wb_dat_i[tb_timer_pkg::UIF_BIT])
         updateFlag <= 1'b0;
   end

   // Read mux, registered data and ack
   logic [31:0] rdData;
   always_comb
   begin
      rdData = 32'h0000_0000;
      if (selCtrl)
         rdData = {24'h000000, ctrl.preload_enable, 4'h0, ctrl.update_source_select, ctrl.update_disable, ctrl.counter_enable};
      else if (selStatus)
         rdData = {31'h0, updateFlag};
      else if (selMask)
         rdData = {31'h0, updateMask};
      else if (selCount)
         rdData = {16'h0000, count};
      else if (selDiv)
         rdData = {16'h0000, dividerSetting};
      else if (selReload)
         rdData = {16'h0000, reloadPreload};
      else if (selRepeat)
         rdData = {24'h000000, repeatSetting};
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= access;
         wb_dat_o <= rdData;
      end
   end

   // [RULE10] wrap to zero
   property p_ovf_wraps;
      @(posedge clk) disable iff (!rstn) (overflow && !countWr) |=> count == 16'h0000;
   endproperty
   a_ovf_wraps: assert property (p_ovf_wraps) else $error("count did not wrap"); // [RULE10]

   // [RULE6] gated when disabled
   property p_gate;
      @(posedge clk) disable iff (!rstn) (!ctrl.counter_enable && !cenLate && !swUpdate && !countWr) |=> $stable(count);
   endproperty
   a_gate: assert property (p_gate) else $error("count moved while disabled"); // [RULE6]

   // [RULE13] no update when disabled
   property p_update_disable;
      @(posedge clk) disable iff (!rstn) ctrl.update_disable |-> !updateEvent;
   endproperty
   a_update_disable: assert property (p_update_disable) else $error("update while disabled"); // [RULE13]

   // [RULE14] restart from zero
   property p_ug;
      @(posedge clk) disable iff (!rstn) (swUpdate && !ctrl.update_disable) |-> updateEvent ##1 count == 16'h0000 && preCount == 16'h0000;
   endproperty
   a_ug: assert property (p_ug) else $error("software update failed"); // [RULE14]

   // [RULE15] quiet software update
   property p_urs;
      @(posedge clk) disable iff (!rstn) (swUpdate && ctrl.update_source_select && !updateFlag) |=> !updateFlag;
   endproperty
   a_urs: assert property (p_urs) else $error("flag set on quiet update"); // [RULE15]

   // [RULE16] flag on update
   property p_flag;
      @(posedge clk) disable iff (!rstn) (updateEvent && !swUpdate) |=> updateFlag;
   endproperty
   a_flag: assert property (p_flag) else $error("flag not set"); // [RULE16]

   // [RULE17] shadows loaded
   property p_shadow;
      @(posedge clk) disable iff (!rstn) updateEvent |=> reloadShadow == $past(reloadPreload) && divBuffer == $past(dividerSetting);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow not loaded"); // [RULE17]

   // [RULE4] shadow follows preload
   property p_arpe0;
      @(posedge clk) disable iff (!rstn) !ctrl.preload_enable |=> reloadShadow == $past(reloadPreload);
   endproperty
   a_arpe0: assert property (p_arpe0) else $error("shadow not following"); // [RULE4]

   // [RULE19] request held
   property p_irq;
      @(posedge clk) disable iff (!rstn) (updateFlag && updateMask) |-> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("request dropped"); // [RULE19]

   // [RULE7] one clock late start
   property p_start;
      @(posedge clk) disable iff (!rstn) ($rose(ctrl.counter_enable) && !swUpdate && !countWr) |=> $stable(count);
   endproperty
   a_start: assert property (p_start) else $error("count moved on enable cycle"); // [RULE7]

   // [RULE1] single step per tick
   property p_step;
      @(posedge clk) disable iff (!rstn) (counterTick && !overflow && !swUpdate && !countWr)
         |=> count == $past(count) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("count did not step"); // [RULE1]

   // [RULE8] prescaler counts up
   property p_pre_step;
      @(posedge clk) disable iff (!rstn) (cenLate && !swUpdate && !preWrap) |=> preCount == $past(preCount) + 16'h0001;
   endproperty
   a_pre_step: assert property (p_pre_step) else $error("prescaler did not step"); // [RULE8]

   // [RULE18] prescaler within ratio
   property p_pre_range;
      @(posedge clk) disable iff (!rstn) preCount <= divBuffer;
   endproperty
   a_pre_range: assert property (p_pre_range) else $error("prescaler beyond divider"); // [RULE18]

   // [RULE9] buffer holds between updates
   property p_div_hold;
      @(posedge clk) disable iff (!rstn) !nextUpdate |=> $stable(divBuffer);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider buffer changed early"); // [RULE9]

   // [RULE4] preloaded shadow holds
   property p_arpe1;
      @(posedge clk) disable iff (!rstn) (ctrl.preload_enable && !nextUpdate) |=> $stable(reloadShadow);
   endproperty
   a_arpe1: assert property (p_arpe1) else $error("shadow changed without update"); // [RULE4]

   // [RULE11] no update mid repetition
   property p_rep_skip;
      @(posedge clk) disable iff (!rstn) (overflow && !repDone && !swUpdate) |-> !updateEvent;
   endproperty
   a_rep_skip: assert property (p_rep_skip) else $error("update before repetitions done"); // [RULE11]

   // [RULE11] repetition counter decrements
   property p_rep_dec;
      @(posedge clk) disable iff (!rstn) (overflow && !repDone && !swUpdate) |=> repeatCount == $past(repeatCount) - 8'h01;
   endproperty
   a_rep_dec: assert property (p_rep_dec) else $error("repetition count did not drop"); // [RULE11]

   // [RULE5] overflow update
   property p_ovf_update;
      @(posedge clk) disable iff (!rstn) (overflow && repDone && !ctrl.update_disable) |-> updateEvent;
   endproperty
   a_ovf_update: assert property (p_ovf_update) else $error("overflow gave no update"); // [RULE5]

   // [RULE17] repetition reloaded
   property p_rep_load;
      @(posedge clk) disable iff (!rstn) updateEvent |=> repeatCount == $past(repeatSetting);
   endproperty
   a_rep_load: assert property (p_rep_load) else $error("repetition not reloaded"); // [RULE17]

   // [RULE2] single cycle ack
   property p_ack;
      @(posedge clk) disable iff (!rstn) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack longer than one cycle"); // [RULE2]

   // [RULE3] reads return preload
   property p_rd_reload;
      @(posedge clk) disable iff (!rstn) (access && !wb_we_i && selReload) |=> wb_dat_o[15:0] == $past(reloadPreload);
   endproperty
   a_rd_reload: assert property (p_rd_reload) else $error("reload read not preload"); // [RULE3]

   c_overflow: cover property (@(posedge clk) disable iff (!rstn) overflow);
   c_update: cover property (@(posedge clk) disable iff (!rstn) updateEvent && !swUpdate);
   c_irq: cover property (@(posedge clk) disable iff (!rstn) irq);
   c_quiet: cover property (@(posedge clk) disable iff (!rstn) swUpdate && ctrl.update_source_select && updateEvent);
   c_repeat: cover property (@(posedge clk) disable iff (!rstn) overflow && !repDone);
endmodule
`default_nettype wire
